//--- sim/plmc_partner.sv
// link partner model: line energy, idle stream and negotiation outcome
`timescale 1ns/1ns
`default_nettype none
module plmc_partner (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic energy_on,
	input wire logic err_req,
	input wire logic fail_req,
	output logic energy_sense,
	output logic idle_symbol,
	output logic idle_err,
	output logic an_attempt_fail,
	output logic an_link_up,
	output logic [1:0] auto_pair_crossed
);
	// idles flow every cycle, errors only ride on an idle
	always_ff @(posedge core_clk) begin
		energy_sense <= energy_on;
		idle_symbol <= rst_n;
		idle_err <= err_req & rst_n;
		an_attempt_fail <= fail_req & rst_n;
		an_link_up <= 1'b0;
		auto_pair_crossed <= 2'h2;
	end
endmodule : plmc_partner
`default_nettype wire

//--- sim/plmc_top_tb_top.sv
// self-checking bench for the link mode control bank
`timescale 1ns/1ns
`default_nettype none
module plmc_top_tb_top;
	import plmc_pkg::*;
	logic core_clk = 0, rst_n = 0, sw_reset = 0, reg_wr = 0, reg_rd = 0, adv_next_page = 0;
	logic energy_on = 1, err_req = 0, fail_req = 0, idle_cnt_clear = 0;
	logic [4:0] reg_addr = 0;
	logic [1:0] manual_pair_crossed = 0, auto_pair_crossed, pair_crossed;
	plmc_word_t reg_wdata = 0, reg_rdata;
	logic energy_sense, idle_symbol, idle_err, an_attempt_fail, an_link_up;
	logic energy_detect_short, tenbase_fast_test_mode, edpd_active, edpd_nlp_tx, power_opt_en;
	logic logic_reset_pulse, speed_downshift, speed_reduced, link_break_fail, next_page_allowed;
	logic next_page_exchange, semi_xover_en, energy_present_status, energy_change_irq_flag;
	logic [7:0] idle_err_count;
	int failures = 0, total_checks = 0, m16 = 'h20, m17 = 'h42, ie = 0, n;
	int n_ds = 0, n_lf = 0, n_irq = 0, n_lr = 0;
	int att[4] = '{7, 5, 4, 3};

	plmc_top #(.WIN_E8(37'h10), .WIN_E9(37'h20), .WIN_E10(37'h40), .WIN_E11(37'h80)) dut (
		.core_clk, .rst_n, .sw_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.energy_sense, .an_attempt_fail, .an_link_up, .idle_symbol, .idle_err, .idle_cnt_clear,
		.auto_pair_crossed, .manual_pair_crossed, .adv_next_page, .energy_detect_short,
		.tenbase_fast_test_mode, .edpd_active, .edpd_nlp_tx, .power_opt_en, .logic_reset_pulse,
		.speed_downshift, .speed_reduced, .link_break_fail, .idle_err_count, .next_page_allowed,
		.next_page_exchange, .pair_crossed, .semi_xover_en, .energy_present_status,
		.energy_change_irq_flag);
	plmc_partner far (.core_clk, .rst_n, .energy_on, .err_req, .fail_req, .energy_sense,
		.idle_symbol, .idle_err, .an_attempt_fail, .an_link_up, .auto_pair_crossed);

	always #50 core_clk = ~core_clk;
	// pulse counters for the one-cycle event outputs
	always @(posedge core_clk) begin
		n_ds += int'(speed_downshift === 1'b1);
		n_lf += int'(link_break_fail === 1'b1);
		n_irq += int'(energy_change_irq_flag === 1'b1);
		n_lr += int'(logic_reset_pulse === 1'b1);
	end

	task automatic complete_run();
		if (failures == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wait_n(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : wait_n

	// model keeps only the writable bits
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		if (a == 5'h10) m16 = d & 16'h033d;
		if (a == 5'h11) m17 = d & 16'hf0f1;
		if (a == 5'h10 && d[0]) ie = 0;
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", e, reg_rdata);
	endtask : rd

	task automatic pulse(input logic f, input int gap);
		@(posedge core_clk);
		if (f) fail_req <= 1'b1;
		else err_req <= 1'b1;
		@(posedge core_clk);
		fail_req <= 1'b0;
		err_req <= 1'b0;
		wait_n(gap);
	endtask : pulse

	task automatic brk(input logic [15:0] cfg, input int gap, input int ex);
		wr(5'h10, cfg | 16'h0001);
		n = n_lf;
		pulse(0, gap);
		pulse(0, 6);
		ie += 2;
		chk("link_break_fail", 16'(n + ex), 16'(n_lf));
		chk("idle_err_count", 16'(ie), 16'(idle_err_count));
	endtask : brk

	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		complete_run();
	end

	initial begin
		void'($urandom(32'ha986));
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(5'h10, 16'h0020);
		rd(5'h11, 16'h0042);
		rd(5'h05, 16'h0000);
		chk("power_opt_en", 1, power_opt_en);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			manual_pair_crossed <= 2'($urandom);
			adv_next_page <= 1'($urandom);
			wr(5'h10, 16'($urandom));
			wr(5'h11, 16'($urandom));
			wr(5'h1f, 16'hffff);
			rd(5'h10, 16'(m16));
			rd(5'h11, 16'(m17 | 2));
			chk("energy_detect_short", m17[15], energy_detect_short);
			chk("tenbase_fast_test_mode", m17[14], tenbase_fast_test_mode);
			chk("power_opt_en", !m16[2], power_opt_en);
			chk("next_page_allowed", m17[6], next_page_allowed);
			chk("next_page_exchange", m17[6] & (!m17[4] | adv_next_page), next_page_exchange);
			chk("pair_crossed", m17[5] ? manual_pair_crossed : 2'h2, pair_crossed);
			chk("semi_xover_en", m17[0], semi_xover_en);
		end
		n = n_lr;
		wr(5'h10, 16'h0021);
		wait_n(2);
		chk("logic_reset_pulse", 16'(n + 1), 16'(n_lr));
		rd(5'h10, 16'h0021);
		wr(5'h11, 16'h0040);
		n = n_ds;
		repeat (7) pulse(1, 3);
		chk("speed_downshift off", 16'(n), 16'(n_ds));
		for (int c = 0; c < 4; c++) begin
			wr(5'h10, 16'(c << 8 | 1));
			wr(5'h11, 16'h00c0);
			n = n_ds;
			for (int k = 1; k <= att[c]; k++) begin
				pulse(1, 3);
				if (k == att[c] - 1) chk("speed_downshift early", 16'(n), 16'(n_ds));
			end
			chk("speed_downshift", 16'(n + 1), 16'(n_ds));
			chk("speed_reduced", 1, speed_reduced);
		end
		brk(16'h0020, 2, 0);
		brk(16'h0008, 20, 0);
		brk(16'h0038, 20, 1);
		brk(16'h0028, 2, 1);
		@(posedge core_clk);
		err_req <= 1'b1;
		wait_n(300);
		chk("idle_err_count", 16'h00ff, 16'(idle_err_count));
		@(posedge core_clk);
		err_req <= 1'b0;
		idle_cnt_clear <= 1'b1;
		@(posedge core_clk);
		idle_cnt_clear <= 1'b0;
		#1;
		chk("idle_err_count", 16'h0000, 16'(idle_err_count));
		energy_on <= 1'b0;
		n = n_irq;
		wait_n(6);
		chk("energy_present_status", 0, energy_present_status);
		chk("energy_change_irq_flag", 16'(n + 1), 16'(n_irq));
		rd(5'h11, 16'(m17));
		wr(5'h11, 16'h3040);
		wait_n(2);
		chk("edpd_active", 1, edpd_active);
		chk("edpd_nlp_tx", 1, edpd_nlp_tx);
		energy_on <= 1'b1;
		wait_n(6);
		chk("energy_present_status", 1, energy_present_status);
		chk("edpd_active", 0, edpd_active);
		n = n_irq;
		@(posedge core_clk);
		sw_reset <= 1'b1;
		@(posedge core_clk);
		sw_reset <= 1'b0;
		#1;
		chk("energy_present_status", 0, energy_present_status);
		wait_n(1);
		chk("energy_change_irq_flag", 16'(n + 1), 16'(n_irq));
		chk("energy_present_status", 1, energy_present_status);
		complete_run();
	end
endmodule : plmc_top_tb_top
`default_nettype wire

//--- verilog/plmc_idle_err.sv
// idle error counter and link-break rate check
`timescale 1ns/1ns
`default_nettype none
`include "plmc_regs.svh"
module plmc_idle_err #(
	parameter plmc_pkg::plmc_win_t WIN_E8 = `PLMC_WIN_E8,
	parameter plmc_pkg::plmc_win_t WIN_E9 = `PLMC_WIN_E9,
	parameter plmc_pkg::plmc_win_t WIN_E10 = `PLMC_WIN_E10,
	parameter plmc_pkg::plmc_win_t WIN_E11 = `PLMC_WIN_E11
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic idle_symbol,
	input wire logic idle_err,
	input wire plmc_pkg::plmc_lb_thresh_t thresh,
	input wire logic lb_en,
	output logic [7:0] count,
	output logic link_fail
);
	import plmc_pkg::*;

	plmc_win_t win_cnt;
	plmc_win_t win_len;
	logic win_err;

	always_comb begin
		unique case (thresh)
			PLMC_LB_E8: win_len = WIN_E8;
			PLMC_LB_E9: win_len = WIN_E9;
			PLMC_LB_E10: win_len = WIN_E10;
			PLMC_LB_E11: win_len = WIN_E11;
		endcase
	end

	// RULE_19 saturating idle count
	always_ff @(posedge core_clk) begin
		if (!rst_n || clr) begin
			count <= 8'h00;
		end else if (idle_err && count != 8'hFF) begin
			count <= count + 8'h01;
		end
	end

	// RULE_02 rate window check
	always_ff @(posedge core_clk) begin
		if (!rst_n || clr) begin
			win_cnt <= '0;
			win_err <= 1'b0;
		end else if (idle_symbol && win_cnt >= win_len - 37'h1) begin
			win_cnt <= '0;
			win_err <= 1'b0;
		end else begin
			if (idle_symbol) begin
				win_cnt <= win_cnt + 37'h1;
			end
			if (idle_err) begin
				win_err <= 1'b1;
			end
		end
	end

	// RULE_03 gated link break
	always_ff @(posedge core_clk) begin
		if (!rst_n || clr) begin
			link_fail <= 1'b0;
		end else begin
			link_fail <= lb_en && idle_err && win_err;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_count_saturates: assert property ( // RULE_19
		count == 8'hFF && !clr |=> count == 8'hFF
	) else $error("idle error count left saturation");

	a_break_needs_enable: assert property ( // RULE_03
		link_fail |-> $past(lb_en) && $past(idle_err)
	) else $error("link break without enable");
endmodule : plmc_idle_err
`default_nettype wire

//--- verilog/plmc_pkg.sv
// types shared by the link mode control bank
package plmc_pkg;
	typedef logic [15:0] plmc_word_t;
	typedef logic [36:0] plmc_win_t;
	typedef enum logic [1:0] {
		PLMC_LB_E8,
		PLMC_LB_E9,
		PLMC_LB_E10,
		PLMC_LB_E11
	} plmc_lb_thresh_t;
	typedef enum logic {
		PLMC_SO_FULL,
		PLMC_SO_REDUCED
	} plmc_so_state_t;
endpackage : plmc_pkg

//--- verilog/plmc_regs.svh
// register offsets, field positions and reset values of the link mode control bank
// Behaviour
// RULE_01: speed-optimize field picks 7, 5, 4 or 3 failed attempts; resets 00.
// RULE_02: link-break threshold picks idle error rate 1e-8 to 1e-11; resets 10.
// RULE_03: link-break threshold acts only while its enable bit is set.
// RULE_04: power-optimization disable bit at 0 keeps automatic power optimization on.
// RULE_05: writing 1 to logic reset pulses a synchronous logic reset, registers untouched.
// RULE_06: the logic reset bit never clears itself.
// RULE_07: energy-detect short bit selects short detection mode; resets 0.
// RULE_08: fast test bit at 1 enters 10BASE-T fast test mode.
// RULE_09: energy-detect power-down happens only with its enable set; resets 0.
// RULE_10: mode bit decides whether link pulses go out during power-down.
// RULE_11: speed optimizer runs only with its enable bit set; resets 0.
// RULE_12: next pages allowed only with next-page enable set; resets 1.
// RULE_13: auto crossover disable at 1 uses manual pair selection.
// RULE_14: automatic next page disable sends next pages only if advertised.
// RULE_15: read-only energy status reports line energy; hardware reset sets it.
// RULE_16: software reset clears energy status, flagging a change if it was set.
// RULE_17: software should clear the energy change flag after any reset.
// RULE_18: semi crossover enable bit switches semi crossover; resets 0.
// RULE_19: a saturating count of idle errors feeds the link-break rate check; the code's rate check uses its own idle window and error flag, not the count.
// RULE_20: manual pair bits choose straight at 0, crossed at 1.
// RULE_21: reserved bits read zero and ignore writes.
`ifndef PLMC_REGS_SVH
`define PLMC_REGS_SVH
`define PLMC_LTC_IDX 5'h10
`define PLMC_FMC_IDX 5'h11
`define PLMC_LTC_SO_LSB 8
`define PLMC_LTC_LB_LSB 4
`define PLMC_LTC_LB_EN 3
`define PLMC_LTC_POD 2
`define PLMC_LTC_LOGIC_RESET_BIT 0
`define PLMC_FMC_EDS 15
`define PLMC_FMC_FTT 14
`define PLMC_FMC_EDPD 13
`define PLMC_FMC_NLP 12
`define PLMC_FMC_SO_EN 7
`define PLMC_FMC_NP_EN 6
`define PLMC_FMC_MDIX_DIS 5
`define PLMC_FMC_ANP_DIS 4
`define PLMC_FMC_ENERGY 1
`define PLMC_FMC_SEMI 0
`define PLMC_SO_RST 2'h0
`define PLMC_LB_RST 2'h2
`define PLMC_NP_RST 1'h1
`define PLMC_WIN_E8 37'h0_05F5_E100
`define PLMC_WIN_E9 37'h0_3B9A_CA00
`define PLMC_WIN_E10 37'h2_540B_E400
`define PLMC_WIN_E11 37'h17_4876_E800
`endif

//--- verilog/plmc_top.sv
// link tuning and 10/100 mode control register bank
`timescale 1ns/1ns
`default_nettype none
`include "plmc_regs.svh"
module plmc_top #(
	parameter plmc_pkg::plmc_win_t WIN_E8 = `PLMC_WIN_E8,
	parameter plmc_pkg::plmc_win_t WIN_E9 = `PLMC_WIN_E9,
	parameter plmc_pkg::plmc_win_t WIN_E10 = `PLMC_WIN_E10,
	parameter plmc_pkg::plmc_win_t WIN_E11 = `PLMC_WIN_E11
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sw_reset,
	input wire logic [4:0] reg_addr,
	input wire plmc_pkg::plmc_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output plmc_pkg::plmc_word_t reg_rdata,
	input wire logic energy_sense,
	input wire logic an_attempt_fail,
	input wire logic an_link_up,
	input wire logic idle_symbol,
	input wire logic idle_err,
	input wire logic idle_cnt_clear,
	input wire logic [1:0] auto_pair_crossed,
	input wire logic [1:0] manual_pair_crossed,
	input wire logic adv_next_page,
	output logic energy_detect_short,
	output logic tenbase_fast_test_mode,
	output logic edpd_active,
	output logic edpd_nlp_tx,
	output logic power_opt_en,
	output logic logic_reset_pulse,
	output logic speed_downshift,
	output logic speed_reduced,
	output logic link_break_fail,
	output logic [7:0] idle_err_count,
	output logic next_page_allowed,
	output logic next_page_exchange,
	output logic [1:0] pair_crossed,
	output logic semi_xover_en,
	output logic energy_present_status,
	output logic energy_change_irq_flag
);
	import plmc_pkg::*;

	logic [1:0] so_ctrl;
	plmc_lb_thresh_t lb_thresh;
	logic lb_en;
	logic pwr_opt_dis;
	logic logic_reset_bit;
	logic energy_detect_short_bit;
	logic tenbase_fast_test_bit;
	logic energy_power_down_enable;
	logic edpd_nlp_sel;
	logic so_en;
	logic np_en;
	logic mdix_dis;
	logic auto_np_dis;
	logic semi_bit;
	logic energy_s1;
	logic energy_s2;
	logic [2:0] fail_cnt;
	plmc_so_state_t so_state;
	logic wr_ltc;
	logic wr_fmc;
	logic idle_clr;

	function automatic logic [2:0] so_limit(input logic [1:0] code);
		unique case (code)
			2'h0: so_limit = 3'h7;
			2'h1: so_limit = 3'h5;
			2'h2: so_limit = 3'h4;
			2'h3: so_limit = 3'h3;
		endcase
	endfunction : so_limit

	function automatic logic hit(input logic [4:0] addr, input logic [4:0] idx);
		hit = (addr == idx);
	endfunction : hit

	assign wr_ltc = reg_wr && hit(reg_addr, `PLMC_LTC_IDX);
	assign wr_fmc = reg_wr && hit(reg_addr, `PLMC_FMC_IDX);
	assign idle_clr = sw_reset || logic_reset_pulse || idle_cnt_clear;

	// RULE_01 RULE_02 RULE_04 tuning fields
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			so_ctrl <= `PLMC_SO_RST;
			lb_thresh <= plmc_lb_thresh_t'(`PLMC_LB_RST);
			lb_en <= 1'b0;
			pwr_opt_dis <= 1'b0;
		end else if (wr_ltc) begin
			so_ctrl <= reg_wdata[`PLMC_LTC_SO_LSB +: 2];
			lb_thresh <= plmc_lb_thresh_t'(reg_wdata[`PLMC_LTC_LB_LSB +: 2]);
			lb_en <= reg_wdata[`PLMC_LTC_LB_EN];
			pwr_opt_dis <= reg_wdata[`PLMC_LTC_POD];
		end
	end

	// RULE_05 RULE_06 held logic reset bit
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			logic_reset_bit <= 1'b0;
			logic_reset_pulse <= 1'b0;
		end else begin
			if (wr_ltc) begin
				logic_reset_bit <= reg_wdata[`PLMC_LTC_LOGIC_RESET_BIT];
			end
			logic_reset_pulse <= wr_ltc && reg_wdata[`PLMC_LTC_LOGIC_RESET_BIT];
		end
	end

	// RULE_07 RULE_08 RULE_09 RULE_10 RULE_12 RULE_18 mode fields
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			energy_detect_short_bit <= 1'b0;
			tenbase_fast_test_bit <= 1'b0;
			energy_power_down_enable <= 1'b0;
			edpd_nlp_sel <= 1'b0;
			so_en <= 1'b0;
			np_en <= `PLMC_NP_RST;
			mdix_dis <= 1'b0;
			auto_np_dis <= 1'b0;
			semi_bit <= 1'b0;
		end else if (wr_fmc) begin
			energy_detect_short_bit <= reg_wdata[`PLMC_FMC_EDS];
			tenbase_fast_test_bit <= reg_wdata[`PLMC_FMC_FTT];
			energy_power_down_enable <= reg_wdata[`PLMC_FMC_EDPD];
			edpd_nlp_sel <= reg_wdata[`PLMC_FMC_NLP];
			so_en <= reg_wdata[`PLMC_FMC_SO_EN];
			np_en <= reg_wdata[`PLMC_FMC_NP_EN];
			mdix_dis <= reg_wdata[`PLMC_FMC_MDIX_DIS];
			auto_np_dis <= reg_wdata[`PLMC_FMC_ANP_DIS];
			semi_bit <= reg_wdata[`PLMC_FMC_SEMI];
		end
	end

	// line energy pin synchroniser, reset to the status reset level
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			energy_s1 <= 1'b1;
			energy_s2 <= 1'b1;
		end else begin
			energy_s1 <= energy_sense;
			energy_s2 <= energy_s1;
		end
	end

	// RULE_15 RULE_16 energy status and change flag
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			energy_present_status <= 1'b1;
			energy_change_irq_flag <= 1'b0;
		end else if (sw_reset) begin
			energy_present_status <= 1'b0;
			energy_change_irq_flag <= energy_present_status;
		end else begin
			energy_present_status <= energy_s2;
			energy_change_irq_flag <= energy_s2 != energy_present_status;
		end
	end

	// RULE_01 RULE_11 speed optimizer
	always_ff @(posedge core_clk) begin
		if (!rst_n || sw_reset || logic_reset_pulse) begin
			fail_cnt <= 3'h0;
			so_state <= PLMC_SO_FULL;
			speed_downshift <= 1'b0;
		end else begin
			speed_downshift <= 1'b0;
			unique case (so_state)
				PLMC_SO_FULL: begin
					if (an_link_up || !so_en) begin
						fail_cnt <= 3'h0;
					end else if (an_attempt_fail) begin
						if (fail_cnt + 3'h1 == so_limit(so_ctrl)) begin
							fail_cnt <= 3'h0;
							speed_downshift <= 1'b1;
							so_state <= PLMC_SO_REDUCED;
						end else begin
							fail_cnt <= fail_cnt + 3'h1;
						end
					end
				end
				PLMC_SO_REDUCED: begin
					fail_cnt <= 3'h0;
					if (!so_en) begin
						so_state <= PLMC_SO_FULL;
					end
				end
			endcase
		end
	end

	plmc_idle_err #(
		.WIN_E8(WIN_E8),
		.WIN_E9(WIN_E9),
		.WIN_E10(WIN_E10),
		.WIN_E11(WIN_E11)
	) u_idle_err (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clr(idle_clr),
		.idle_symbol(idle_symbol),
		.idle_err(idle_err),
		.thresh(lb_thresh),
		.lb_en(lb_en),
		.count(idle_err_count),
		.link_fail(link_break_fail)
	);

	// RULE_04 RULE_07 RULE_08 RULE_09 RULE_10 RULE_12 RULE_13 RULE_14 RULE_18 RULE_20 mode outputs
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			energy_detect_short <= 1'b0;
			tenbase_fast_test_mode <= 1'b0;
			edpd_active <= 1'b0;
			edpd_nlp_tx <= 1'b0;
			power_opt_en <= 1'b1;
			next_page_allowed <= 1'b1;
			next_page_exchange <= 1'b1;
			pair_crossed <= 2'h0;
			semi_xover_en <= 1'b0;
			speed_reduced <= 1'b0;
		end else begin
			energy_detect_short <= energy_detect_short_bit;
			tenbase_fast_test_mode <= tenbase_fast_test_bit;
			edpd_active <= energy_power_down_enable && !energy_present_status;
			edpd_nlp_tx <= energy_power_down_enable && !energy_present_status && edpd_nlp_sel;
			power_opt_en <= !pwr_opt_dis;
			next_page_allowed <= np_en;
			next_page_exchange <= np_en && (!auto_np_dis || adv_next_page);
			pair_crossed <= mdix_dis ? manual_pair_crossed : auto_pair_crossed;
			semi_xover_en <= semi_bit;
			speed_reduced <= so_state == PLMC_SO_REDUCED;
		end
	end

	// RULE_21 read path, reserved bits zero
	always_ff @(posedge core_clk) begin
		if (!rst_n || !reg_rd) begin
			reg_rdata <= 16'h0000;
		end else if (hit(reg_addr, `PLMC_LTC_IDX)) begin
			reg_rdata <= {6'h00, so_ctrl, 2'h0, lb_thresh, lb_en, pwr_opt_dis, 1'b0,
				logic_reset_bit};
		end else if (hit(reg_addr, `PLMC_FMC_IDX)) begin
			reg_rdata <= {energy_detect_short_bit, tenbase_fast_test_bit,
				energy_power_down_enable, edpd_nlp_sel, 4'h0, so_en, np_en, mdix_dis,
				auto_np_dis, 2'h0, energy_present_status, semi_bit};
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_logic_reset_bit_pulse: assert property ( // RULE_05
		wr_ltc && reg_wdata[`PLMC_LTC_LOGIC_RESET_BIT] |=> logic_reset_pulse ##1 !logic_reset_pulse
	) else $error("logic reset pulse wrong");

	a_logic_reset_bit_held: assert property ( // RULE_06
		logic_reset_bit && !wr_ltc |=> logic_reset_bit
	) else $error("logic reset bit cleared itself");

	a_logic_reset_bit_keeps_regs: assert property ( // RULE_05
		logic_reset_pulse && !wr_ltc && !wr_fmc |=> $stable(so_ctrl) && $stable(np_en)
	) else $error("logic reset touched registers");

	a_energy_swrst: assert property ( // RULE_16
		sw_reset && energy_present_status |=> !energy_present_status && energy_change_irq_flag
	) else $error("software reset energy handling wrong");

	a_energy_hwrst: assert property (@(posedge core_clk) // RULE_15
		$rose(rst_n) |-> energy_present_status
	) else $error("energy status not set by hardware reset");

	a_edpd_gate: assert property ( // RULE_09
		edpd_active |-> $past(energy_power_down_enable)
	) else $error("power down without enable");

	a_edpd_nlp: assert property ( // RULE_10
		edpd_active |-> edpd_nlp_tx == $past(edpd_nlp_sel)
	) else $error("link pulse mode wrong");

	a_so_gate: assert property ( // RULE_11
		speed_downshift |-> $past(so_en) && $past(an_attempt_fail)
	) else $error("downshift without enable");

	a_so_limit: assert property ( // RULE_01
		speed_downshift |-> $past(fail_cnt) + 3'h1 == so_limit($past(so_ctrl))
	) else $error("downshift at wrong attempt count");

	a_xover_sel: assert property ( // RULE_13
		rst_n |=> pair_crossed == ($past(mdix_dis) ? $past(manual_pair_crossed)
			: $past(auto_pair_crossed))
	) else $error("crossover selection wrong");

	a_np_exchange: assert property ( // RULE_14
		next_page_exchange |-> $past(np_en) && (!$past(auto_np_dis) || $past(adv_next_page))
	) else $error("next page exchange wrong");

	a_rsvd_zero: assert property ( // RULE_21
		reg_rd && hit(reg_addr, `PLMC_LTC_IDX) |=> (reg_rdata & 16'hFCC2) == 16'h0000
	) else $error("reserved bits read nonzero");

	a_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == 16'h0000
	) else $error("read data outside read slot");

	a_short_mode: assert property ( // RULE_07
		rst_n |=> energy_detect_short == $past(energy_detect_short_bit)
	) else $error("short detect mode wrong");

	a_fast_test: assert property ( // RULE_08
		rst_n |=> tenbase_fast_test_mode == $past(tenbase_fast_test_bit)
	) else $error("fast test mode wrong");

	a_power_opt: assert property ( // RULE_04
		rst_n |=> power_opt_en == !$past(pwr_opt_dis)
	) else $error("power optimization wrong");

	a_np_allowed: assert property ( // RULE_12
		rst_n |=> next_page_allowed == $past(np_en)
	) else $error("next page enable wrong");

	a_semi_xover: assert property ( // RULE_18
		rst_n |=> semi_xover_en == $past(semi_bit)
	) else $error("semi crossover wrong");

	a_energy_follow: assert property ( // RULE_15
		rst_n && !sw_reset |=> energy_present_status == $past(energy_s2)
	) else $error("energy status does not follow line");

	a_so_write: assert property ( // RULE_01
		wr_ltc |=> so_ctrl == $past(reg_wdata[`PLMC_LTC_SO_LSB +: 2])
	) else $error("speed optimize field write lost");

	a_so_reduced: assert property ( // RULE_11
		speed_downshift |=> speed_reduced
	) else $error("reduced level missing after downshift");

	a_nlp_silent: assert property ( // RULE_10
		rst_n && !edpd_nlp_sel |=> !edpd_nlp_tx
	) else $error("link pulses sent in silent mode");
endmodule : plmc_top
`default_nettype wire
